// ---- cpu_core_model.sv ----
// cpu core model: takes a request, runs its handler, returns
`timescale 1ns/1ns
module cpu_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cpu_req,
	output logic cpu_ack,
	output logic cpu_return
);
	logic [3:0] run_reg;
	// one handler at a time, so a new request waits for the return
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_ack <= 1'b0;
			cpu_return <= 1'b0;
			run_reg <= 4'h0;
		end else begin
			cpu_ack <= cpu_req && run_reg == 4'h0 && !cpu_ack;
			cpu_return <= run_reg == 4'h1;
			if (cpu_ack)
				run_reg <= 4'h8;
			else if (run_reg != 4'h0)
				run_reg <= run_reg - 4'h1;
		end
	end
endmodule

// ---- irq_prio_ctrl.sv ----
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
// interrupt priority, masking and entry/return control with apb registers
//
// Overview of operation
// - each source has a three-bit level, 111 highest, 001 lowest.
// - a level field of 000 stops the source from ever requesting.
// - reset puts every user level field at 100, level four.
// - unimplemented priority register bits read zero and ignore writes.
// - fields sit at bits 14-12, 10-8, 6-4, 2-0; gaps unimplemented.
// - nesting disable at control bit 15 blocks preemption of active service by user sources; traps still preempt.
// - a source requests only with both its flag and enable set.
// - flags stay set until cleared; a set flag re-enters after return.
// - return restores saved level and status low byte.
// - trap flags stay set until cleared and re-enter their handler.
// - cpu level seven masks all user sources.
// - restoring a lower cpu level re-enables higher user sources.
// - traps at levels 8 to 11 are never masked.
// - timed disable blocks levels 1 to 6 for a set period.
// - level seven sources still interrupt during timed disable.
module irq_prio_ctrl
	import irq_prio_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_SRC-1:0] src_event,
	input wire logic [NUM_TRAP-1:0] trap_event,
	input wire logic cpu_ack,
	input wire logic cpu_return,
	output logic cpu_req,
	output logic [3:0] cpu_req_level,
	output logic [3:0] cpu_req_index,
	output logic cpu_req_trap,
	output logic [3:0] cpu_level,
	output logic irq
);
	logic [15:0] prio_reg [5];
	logic nest_dis_reg;
	logic [NUM_TRAP-1:0] trap_flag_reg;
	logic [NUM_SRC-1:0] flag_reg;
	logic [NUM_SRC-1:0] enable_reg;
	logic [3:0] level_reg;
	logic [7:0] status_low_reg;
	logic [3:0] save_level_reg [16];
	logic [7:0] save_status_reg [16];
	logic [3:0] depth_reg;
	logic [NUM_EV-1:0] ev_status_reg;
	logic [NUM_EV-1:0] ev_enable_reg;
	logic [3*NUM_SRC-1:0] prio_flat;
	logic [15:0] prio_mask [5];
	irq_req_t winner;
	logic tdis_active;
	logic tdis_done;
	logic wr_en;
	logic rd_en;
	logic [4:0] wr_idx;
	logic addr_ok;
	logic allowed;
	logic [NUM_EV-1:0] ev_set;
	logic [31:0] read_word;

	assign prio_mask[0] = PRIO_MASK_TOUCH;
	assign prio_mask[1] = PRIO_MASK_UART3;
	assign prio_mask[2] = PRIO_MASK_U4E_I2C3;
	assign prio_mask[3] = PRIO_MASK_SPI3_U4;
	assign prio_mask[4] = PRIO_MASK_CAP_CMP;

	// apb strobes; zero wait state slave
	// refused offsets must not alias onto a register through the unused address bits
	assign wr_en = psel && penable && pwrite && addr_ok;
	assign rd_en = psel && !penable && !pwrite;
	assign wr_idx = paddr[6:2];

	// unpack source levels into one vector, order fixed by register layout
	assign prio_flat = {
		prio_reg[4][2:0], prio_reg[4][6:4],
		prio_reg[3][2:0], prio_reg[3][6:4], prio_reg[3][10:8], prio_reg[3][14:12],
		prio_reg[2][2:0], prio_reg[2][6:4], prio_reg[2][14:12],
		prio_reg[1][6:4], prio_reg[1][10:8], prio_reg[1][14:12],
		prio_reg[0][6:4]
	};

	prio_arbiter u_arb (
		.pending(flag_reg & enable_reg),
		.prio(prio_flat),
		.trap_pending(trap_flag_reg),
		.winner(winner)
	);

	timed_disable u_tdis (
		.pclk(pclk),
		.presetn(presetn),
		.load(wr_en && paddr == ADDR_TIMED_DIS),
		.count(pwdata[13:0]),
		.active(tdis_active),
		.done(tdis_done)
	);

	// decide whether the winner may interrupt now
	always_comb begin
		allowed = 1'b0;
		if (winner.valid) begin
			if (winner.is_trap) begin
				allowed = 1'b1;
			end else if (winner.level > level_reg) begin
				// nesting disable holds off user-source preemption of a running handler
				if (!(nest_dis_reg && depth_reg != 4'h0)) begin
					// timed window spares level seven only
					allowed = !tdis_active || winner.level == LEVEL_TOP_USER;
				end
			end
		end
	end

	// priority registers: writable fields only, masks drop the gaps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// constants only, so the reset path never depends on other logic
			prio_reg[0] <= PRIO_RESET_WORD & PRIO_MASK_TOUCH;
			prio_reg[1] <= PRIO_RESET_WORD & PRIO_MASK_UART3;
			prio_reg[2] <= PRIO_RESET_WORD & PRIO_MASK_U4E_I2C3;
			prio_reg[3] <= PRIO_RESET_WORD & PRIO_MASK_SPI3_U4;
			prio_reg[4] <= PRIO_RESET_WORD & PRIO_MASK_CAP_CMP;
		end else if (wr_en && wr_idx < 5'h05) begin
			prio_reg[wr_idx[2:0]] <= pwdata[15:0] & prio_mask[wr_idx[2:0]];
		end
	end

	// control one: nesting disable and trap flags, traps cleared by writing 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nest_dis_reg <= 1'b0;
			trap_flag_reg <= '0;
		end else begin
			if (wr_en && paddr == ADDR_CONTROL_ONE) begin
				nest_dis_reg <= pwdata[NEST_DIS_BIT];
				// new trap event wins over a clear in the same cycle
				trap_flag_reg <= (trap_flag_reg & pwdata[NUM_TRAP-1:0]) | trap_event;
			end else begin
				trap_flag_reg <= trap_flag_reg | trap_event;
			end
		end
	end

	// source flags stay until software clears; set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_reg <= '0;
		end else if (wr_en && paddr == ADDR_FLAG_CLR) begin
			flag_reg <= (flag_reg & ~pwdata[NUM_SRC-1:0]) | src_event;
		end else if (wr_en && paddr == ADDR_FLAGS) begin
			flag_reg <= pwdata[NUM_SRC-1:0] | src_event;
		end else begin
			flag_reg <= flag_reg | src_event;
		end
	end

	// enable bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_reg <= '0;
		end else if (wr_en && paddr == ADDR_ENABLE) begin
			enable_reg <= pwdata[NUM_SRC-1:0];
		end
	end

	// cpu level, status low byte and save stack for entry and return
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_reg <= 4'h0;
			status_low_reg <= 8'h00;
			depth_reg <= 4'h0;
			for (int i = 0; i < 16; i++) begin
				save_level_reg[i] <= 4'h0;
				save_status_reg[i] <= 8'h00;
			end
		end else if (cpu_ack && cpu_req) begin
			// entry stacks the old context and raises the level
			save_level_reg[depth_reg] <= level_reg;
			save_status_reg[depth_reg] <= status_low_reg;
			depth_reg <= depth_reg + 4'h1;
			level_reg <= cpu_req_level;
		end else if (cpu_return && depth_reg != 4'h0) begin
			// unstack; a flag still set is caught again next cycle
			level_reg <= save_level_reg[depth_reg - 4'h1];
			status_low_reg <= save_status_reg[depth_reg - 4'h1];
			depth_reg <= depth_reg - 4'h1;
		end else if (wr_en && paddr == ADDR_CPU_STATUS) begin
			// software raises to seven to mask all user sources, or restores
			status_low_reg <= pwdata[7:0];
			level_reg <= {1'b0, pwdata[7:5]};
		end
	end

	// request presented to the cpu while allowed, recomputed each cycle and dropped for a cycle after a take
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_req <= 1'b0;
			cpu_req_level <= 4'h0;
			cpu_req_index <= 4'h0;
			cpu_req_trap <= 1'b0;
		end else begin
			cpu_req <= allowed && !(cpu_ack && cpu_req);
			cpu_req_level <= winner.level;
			cpu_req_index <= winner.index;
			cpu_req_trap <= winner.is_trap;
		end
	end

	assign ev_set = {tdis_done, cpu_ack && cpu_req && cpu_req_trap, cpu_ack && cpu_req};

	// sticky events; set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_status_reg <= '0;
			ev_enable_reg <= '0;
		end else begin
			if (wr_en && paddr == ADDR_IRQ_CLEAR) begin
				ev_status_reg <= (ev_status_reg & ~pwdata[NUM_EV-1:0]) | ev_set;
			end else begin
				ev_status_reg <= ev_status_reg | ev_set;
			end
			if (wr_en && paddr == ADDR_IRQ_ENABLE) begin
				ev_enable_reg <= pwdata[NUM_EV-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
			cpu_level <= 4'h0;
		end else begin
			irq <= |(ev_status_reg & ev_enable_reg);
			cpu_level <= level_reg;
		end
	end

	assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= ADDR_IRQ_ENABLE);

	// read mux; refused and write-only offsets read zero
	always_comb begin
		read_word = 32'h0000_0000;
		if (addr_ok) begin
			unique case (paddr)
				ADDR_PRIO_TOUCH: read_word = {16'h0000, prio_reg[0]};
				ADDR_PRIO_UART3: read_word = {16'h0000, prio_reg[1]};
				ADDR_PRIO_U4E_I2C3: read_word = {16'h0000, prio_reg[2]};
				ADDR_PRIO_SPI3_U4: read_word = {16'h0000, prio_reg[3]};
				ADDR_PRIO_CAP_CMP: read_word = {16'h0000, prio_reg[4]};
				ADDR_CONTROL_ONE:
					read_word = {16'h0000, nest_dis_reg, 11'h000, trap_flag_reg};
				ADDR_FLAGS: read_word = {19'h0, flag_reg};
				ADDR_FLAG_CLR: read_word = 32'h0000_0000; // write-only clear
				ADDR_ENABLE: read_word = {19'h0, enable_reg};
				ADDR_CPU_STATUS: read_word = {20'h0, level_reg, status_low_reg};
				ADDR_TIMED_DIS: read_word = {31'h0, tdis_active};
				ADDR_IRQ_STATUS: read_word = {29'h0, ev_status_reg};
				ADDR_IRQ_CLEAR: read_word = 32'h0000_0000; // write-only clear
				ADDR_IRQ_ENABLE: read_word = {29'h0, ev_enable_reg};
				default: read_word = 32'h0000_0000;
			endcase
		end
	end

	// read data latched in setup phase so it is stable in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (rd_en) begin
				prdata <= read_word;
			end
		end
	end
endmodule

// ---- irq_prio_pkg.sv ----
// shared constants and types for the interrupt priority and masking block
package irq_prio_pkg;
	localparam int NUM_SRC = 13;
	localparam int NUM_TRAP = 4;
	localparam logic [2:0] PRIO_RESET = 3'h4;
	localparam logic [2:0] PRIO_OFF = 3'h0;
	localparam logic [3:0] LEVEL_TOP_USER = 4'h7;
	localparam logic [15:0] PRIO_MASK_TOUCH = 16'h0070;
	localparam logic [15:0] PRIO_MASK_UART3 = 16'h7770;
	localparam logic [15:0] PRIO_MASK_U4E_I2C3 = 16'h7077;
	localparam logic [15:0] PRIO_MASK_SPI3_U4 = 16'h7777;
	localparam logic [15:0] PRIO_MASK_CAP_CMP = 16'h0077;
	localparam logic [15:0] PRIO_RESET_WORD = 16'h4444;
	localparam int FIELD_A_LSB = 12;
	localparam int FIELD_B_LSB = 8;
	localparam int FIELD_C_LSB = 4;
	localparam int FIELD_D_LSB = 0;
	localparam int NEST_DIS_BIT = 15;
	// register byte addresses
	localparam logic [7:0] ADDR_PRIO_TOUCH = 8'h00;
	localparam logic [7:0] ADDR_PRIO_UART3 = 8'h04;
	localparam logic [7:0] ADDR_PRIO_U4E_I2C3 = 8'h08;
	localparam logic [7:0] ADDR_PRIO_SPI3_U4 = 8'h0c;
	localparam logic [7:0] ADDR_PRIO_CAP_CMP = 8'h10;
	localparam logic [7:0] ADDR_CONTROL_ONE = 8'h14;
	localparam logic [7:0] ADDR_FLAGS = 8'h18;
	localparam logic [7:0] ADDR_FLAG_CLR = 8'h1c;
	localparam logic [7:0] ADDR_ENABLE = 8'h20;
	localparam logic [7:0] ADDR_CPU_STATUS = 8'h24;
	localparam logic [7:0] ADDR_TIMED_DIS = 8'h28;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h2c;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h30;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h34;
	// status event bit positions
	localparam int EV_ENTRY = 0;
	localparam int EV_TRAP = 1;
	localparam int EV_TDIS_END = 2;
	localparam int NUM_EV = 3;
	typedef struct packed {
		logic valid;
		logic is_trap;
		logic [3:0] level;
		logic [3:0] index;
	} irq_req_t;
	typedef struct packed {
		logic [3:0] cpu_level;
		logic in_service;
	} cpu_ctx_t;
endpackage

// ---- irq_prio_properties.sv ----
// port assertions for the priority controller
`timescale 1ns/1ns
module irq_prio_properties
	import irq_prio_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cpu_ack,
	input wire logic cpu_req,
	input wire logic [3:0] cpu_req_level,
	input wire logic cpu_req_trap,
	input wire logic [3:0] cpu_level
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable && pready; endsequence
	sequence s_take; cpu_req && cpu_ack; endsequence
	property p_answer; s_setup |=> s_access; endproperty
	property p_ready_in; pready |-> psel && penable; endproperty
	property p_bad; s_setup ##0 (paddr > 8'h34) |=> pslverr; endproperty
	property p_bad_zero; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
	property p_drop; s_take |=> !cpu_req; endproperty
	property p_follow; s_take |-> ##2 cpu_level == $past(cpu_req_level, 2); endproperty
	property p_trap; cpu_req && cpu_req_trap |-> cpu_req_level >= 4'h8; endproperty
	property p_user; cpu_req && !cpu_req_trap |-> cpu_req_level inside {[4'h1:4'h7]}; endproperty
	property p_above; cpu_req && !cpu_req_trap && $stable(cpu_level) |-> cpu_req_level > cpu_level;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer after setup");
	a_ready_in: assert property (p_ready_in) else $error("ready outside access");
	a_bad: assert property (p_bad) else $error("bad address not refused");
	a_bad_zero: assert property (p_bad_zero) else $error("refused read not zero");
	a_drop: assert property (p_drop) else $error("request held after take");
	a_follow: assert property (p_follow) else $error("level not raised on entry");
	a_trap: assert property (p_trap) else $error("trap level below eight");
	a_user: assert property (p_user) else $error("user level out of range");
	a_above: assert property (p_above) else $error("request not above level");
endmodule
bind irq_prio_ctrl irq_prio_properties u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .cpu_ack(cpu_ack), .cpu_req(cpu_req), .cpu_req_level(cpu_req_level),
	.cpu_req_trap(cpu_req_trap), .cpu_level(cpu_level));

// ---- prio_arbiter.sv ----
`timescale 1ns/1ns
// picks the highest-level pending request among user sources and traps
module prio_arbiter
	import irq_prio_pkg::*;
(
	input wire logic [NUM_SRC-1:0] pending,
	input wire logic [3*NUM_SRC-1:0] prio,
	input wire logic [NUM_TRAP-1:0] trap_pending,
	output irq_req_t winner
);
	irq_req_t cand [NUM_SRC+1];
	logic [3:0] trap_lvl;
	logic [3:0] trap_idx;

	// trap level is 8 plus its index; highest index wins
	always_comb begin
		trap_lvl = 4'h0;
		trap_idx = 4'h0;
		for (int t = 0; t < NUM_TRAP; t++) begin
			if (trap_pending[t]) begin
				trap_lvl = 4'h8 + 4'(t);
				trap_idx = 4'(t);
			end
		end
	end

	assign cand[0] = '{valid: |trap_pending, is_trap: 1'b1, level: trap_lvl, index: trap_idx};

	// linear chain; lower index wins ties as natural order
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_chain
			logic [3:0] lvl;
			assign lvl = {1'b0, prio[3*g +: 3]};
			// a field of zero never requests
			assign cand[g+1] = (pending[g] && lvl != 4'h0 &&
				(!cand[g].valid || lvl > cand[g].level)) ?
				'{valid: 1'b1, is_trap: 1'b0, level: lvl, index: 4'(g)} : cand[g];
		end
	endgenerate

	assign winner = cand[NUM_SRC];
endmodule

// ---- tb.sv ----
// self-checking bench for the priority controller
`timescale 1ns/1ns
module tb;
	import irq_prio_pkg::*;
	typedef struct packed {logic [7:0] a; logic [15:0] m;} row_t;
	logic pclk, presetn, psel, penable, pwrite, cpu_ack, cpu_return, cpu_req;
	logic cpu_req_trap, irq, pready, pslverr, last_trap;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [NUM_SRC-1:0] src_event;
	logic [NUM_TRAP-1:0] trap_event;
	logic [3:0] cpu_req_level, cpu_req_index, cpu_level, last_lvl, last_idx;
	int bad_count = 0, n_compared = 0, acks = 0, a0;
	row_t rows [5] = '{'{ADDR_PRIO_TOUCH, PRIO_MASK_TOUCH}, '{ADDR_PRIO_UART3, PRIO_MASK_UART3},
		'{ADDR_PRIO_U4E_I2C3, PRIO_MASK_U4E_I2C3}, '{ADDR_PRIO_SPI3_U4, PRIO_MASK_SPI3_U4},
		'{ADDR_PRIO_CAP_CMP, PRIO_MASK_CAP_CMP}};
	irq_prio_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_event(src_event), .trap_event(trap_event), .cpu_ack(cpu_ack),
		.cpu_return(cpu_return), .cpu_req(cpu_req), .cpu_req_level(cpu_req_level),
		.cpu_req_index(cpu_req_index), .cpu_req_trap(cpu_req_trap), .cpu_level(cpu_level),
		.irq(irq));
	cpu_core_model cpu (.pclk(pclk), .presetn(presetn), .cpu_req(cpu_req), .cpu_ack(cpu_ack),
		.cpu_return(cpu_return));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// note what the cpu took at each entry
	always @(posedge pclk) begin
		if (cpu_ack === 1'b1 && cpu_req === 1'b1) begin
			acks <= acks + 1;
			last_lvl <= cpu_req_level;
			last_idx <= cpu_req_index;
			last_trap <= cpu_req_trap;
		end
	end
	task end_sim;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one apb transfer, held until ready is seen
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		chk(pslverr, a > ADDR_IRQ_ENABLE);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// bounded wait for the cpu to have taken n entries
	task wait_acks(input int n);
		for (int i = 0; i < 300 && acks < n; i++) @(posedge pclk);
		chk(acks >= n, 1'b1);
	endtask
	task pulse(input logic [NUM_SRC-1:0] s, input logic [NUM_TRAP-1:0] t);
		@(posedge pclk);
		src_event <= s;
		trap_event <= t;
		@(posedge pclk);
		src_event <= '0;
		trap_event <= '0;
	endtask
	initial begin
		#300000;
		bad_count++;
		end_sim;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, src_event, trap_event} = '0;
		tick(16);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b0, rows[i].a, 32'h0);
			chk(rd, PRIO_RESET_WORD & rows[i].m);
			wr(rows[i].a, '1);
			apb(1'b0, rows[i].a, 32'h0);
			chk(rd, rows[i].m);
		end
		apb(1'b0, 8'h38, 32'h0);
		chk(rd, 32'h0);
		@(posedge pclk);
		presetn <= 1'b0;
		tick(2);
		presetn <= 1'b1;
		apb(1'b0, ADDR_PRIO_TOUCH, 32'h0);
		chk(rd, 32'h40);
		// setup in order: level, clear flag, enable; then leave flag set
		wr(ADDR_PRIO_TOUCH, 32'h30);
		wr(ADDR_FLAG_CLR, 32'h1);
		wr(ADDR_ENABLE, 32'h1);
		wr(ADDR_IRQ_ENABLE, 32'h1);
		tick(10);
		chk(acks, 0);
		pulse(13'h1, 4'h0);
		wait_acks(2);
		chk(last_lvl, 4'h3);
		chk(last_idx, 4'h0);
		chk(irq, 1'b1);
		wr(ADDR_FLAG_CLR, 32'h1);
		tick(20);
		a0 = acks;
		tick(30);
		chk(acks, a0);
		wr(ADDR_IRQ_ENABLE, 32'h0);
		tick(2);
		chk(irq, 1'b0);
		wr(ADDR_IRQ_CLEAR, 32'h7);
		wr(ADDR_IRQ_ENABLE, 32'h1);
		tick(2);
		chk(irq, 1'b0);
		// level zero never requests
		wr(ADDR_PRIO_TOUCH, 32'h0);
		pulse(13'h1, 4'h0);
		tick(30);
		chk(acks, a0);
		wr(ADDR_PRIO_TOUCH, 32'h70);
		wait_acks(a0 + 1);
		chk(last_lvl, 4'h7);
		wr(ADDR_FLAG_CLR, 32'h1);
		tick(20);
		// cpu level seven masks users, not traps
		a0 = acks;
		wr(ADDR_CPU_STATUS, 32'he0);
		pulse(13'h1, 4'h0);
		tick(30);
		chk(acks, a0);
		pulse(13'h0, 4'h2);
		wait_acks(a0 + 2);
		chk(last_trap, 1'b1);
		chk(last_lvl, 4'h9);
		wr(ADDR_CONTROL_ONE, 32'h0);
		tick(20);
		a0 = acks;
		wr(ADDR_CPU_STATUS, 32'h0);
		wait_acks(a0 + 1);
		chk({last_trap, last_lvl}, 5'h07);
		wr(ADDR_FLAG_CLR, 32'h1);
		tick(20);
		// timed disable holds level six but not seven
		wr(ADDR_PRIO_CAP_CMP, 32'h70);
		wr(ADDR_PRIO_TOUCH, 32'h60);
		// capture nine is source eleven, its field in bits 6-4
		wr(ADDR_FLAG_CLR, 32'h801);
		wr(ADDR_ENABLE, 32'h801);
		a0 = acks;
		wr(ADDR_TIMED_DIS, 32'd200);
		pulse(13'h1, 4'h0);
		tick(20);
		chk(acks, a0);
		pulse(13'h800, 4'h0);
		wait_acks(a0 + 1);
		chk(last_idx, 4'hb);
		wr(ADDR_FLAG_CLR, 32'h800);
		wait_acks(a0 + 2);
		chk({last_idx, last_lvl}, 8'h06);
		apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
		chk(rd[EV_TDIS_END], 1'b1);
		// nesting disabled: a level seven source waits for the level six handler
		wr(ADDR_FLAG_CLR, 32'h1);
		tick(20);
		wr(ADDR_CONTROL_ONE, 32'h8000);
		a0 = acks;
		pulse(13'h1, 4'h0);
		wait_acks(a0 + 1);
		pulse(13'h800, 4'h0);
		tick(2);
		chk(cpu_req, 1'b0);
		wait_acks(a0 + 2);
		chk(last_idx, 4'hb);
		end_sim;
	end
endmodule

// ---- timed_disable.sv ----
`timescale 1ns/1ns
// counts down a software-set window during which levels 1 to 6 are held off
module timed_disable
	import irq_prio_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic [13:0] count,
	output logic active,
	output logic done
);
	logic [13:0] cnt_reg;

	// reload wins over the running count so a new window restarts cleanly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 14'h0000;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				cnt_reg <= count;
			end else if (cnt_reg != 14'h0000) begin
				cnt_reg <= cnt_reg - 14'h0001;
				done <= (cnt_reg == 14'h0001);
			end
		end
	end

	assign active = (cnt_reg != 14'h0000);
endmodule
